// ==== test/flash_cmd_seq_test.sv ====
/* self-checking bench for the command sequencer.
   assumes a short timed write (TW) and a combinational array model. */
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_seq_test;
    import flash_cmd_pkg::*;
    // short write time keeps the run small
    localparam int TW = 600;
    logic         ref_clk_i, resetn_i, sck, cs_n, saw_oe, quad_wide_command_mode;
    logic [7:0]   rparam;
    logic [3:0]   io_h, io_d, oe_d;
    logic [23:0]  addr;
    status_pair_s st, nv;
    logic [2:0]   wrap;
    logic [31:0]  rx;
    int           failures, cmp_count, cyc;
    // array byte derived from address
    wire logic [7:0] arr = addr[7:0] ^ 8'ha5;

    flash_cmd_seq #(.TW_CLKS(TW)) i_flash_cmd_seq (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sck_i(sck),
        .cs_n_i(cs_n), .io_i(io_h), .io_o(io_d), .io_oe_o(oe_d),
        .quad_wide_command_mode_i(quad_wide_command_mode), .read_param_i(rparam),
        .array_addr_o(addr), .array_data_i(arr), .status_o(st),
        .nv_status_o(nv), .wrap_length_o(wrap));
    spi_host_model i_spi_host_model (
        .sck_o(sck), .cs_n_o(cs_n), .io_o(io_h), .io_i(io_d),
        .oe_i(oe_d), .saw_oe_o(saw_oe));

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // hang guard
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    // one frame, then a cs high gap for the frame effect to land
    task automatic cmd(input int ntx, input logic [63:0] tx, input int nrx,
                       input int q = 64);
        i_spi_host_model.frame(ntx, tx, nrx, rx, q);
        repeat (10) @(negedge ref_clk_i);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        resetn_i = 1'b0;
        failures = 0;
        cmp_count = 0;
        cyc = 0;
        quad_wide_command_mode = 1'b0;
        rparam = 8'h00;
        repeat (20) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        check(st, 16'h0000);
        cmd(8, {8'h06, 56'h0}, 0);
        check(st.st1, 8'h02);
        cmd(8, {8'h05, 56'h0}, 16);
        check(rx[15:0], 16'h0202);
        cmd(8, {8'h04, 56'h0}, 0);
        check(st.st1, 8'h00);
        cmd(24, {8'h01, 16'hffff, 40'h0}, 0);
        check(st, 16'h0000);
        cmd(6, {8'h06, 56'h0}, 0);
        check(st.st1, 8'h00);
        $display("test latch done");
        cmd(8, {8'h06, 56'h0}, 0);
        cmd(12, {8'h01, 8'hff, 48'h0}, 0);
        check(st.st1, 8'h02);
        cmd(24, {8'h01, 16'hffff, 40'h0}, 0);
        check(st.st1, 8'h01);
        cmd(8, {8'h05, 56'h0}, 8);
        check(rx[7:0], 8'h01);
        cmd(40, {8'h03, 24'h0, 32'h0}, 8);
        check(saw_oe, 1'b0);
        repeat (TW) @(negedge ref_clk_i);
        check(st, 16'h43fc);
        check(nv, 16'h43fc);
        $display("test status write done");
        cmd(8, {8'h06, 56'h0}, 0);
        cmd(16, {8'h01, 8'h00, 48'h0}, 0);
        repeat (TW) @(negedge ref_clk_i);
        check(st, 16'h0000);
        cmd(8, {8'h06, 56'h0}, 0);
        cmd(16, {8'h31, 8'hff, 48'h0}, 0);
        repeat (TW) @(negedge ref_clk_i);
        check(st, 16'h4300);
        // quad enable is now set: quad read and wrap setting
        cmd(20, {8'heb, 24'h000020, 32'h0}, 4, 8);
        check(rx[15:0], 16'h8584);
        cmd(16, {8'h77, 32'h00000050, 24'h0}, 0, 8);
        check(wrap, 3'h5);
        cmd(8, {8'h50, 56'h0}, 0);
        cmd(16, {8'h01, 8'h1c, 48'h0}, 0);
        check(st, 16'h001c);
        check(nv, 16'h4300);
        $display("test volatile done");
        cmd(32, {8'h03, 24'h0000fe, 32'h0}, 16);
        check(rx[15:0], 16'h5b5a);
        cmd(32, {8'h0b, 24'h000010, 32'h0}, 16);
        check(rx[7:0], 8'hb5);
        quad_wide_command_mode = 1'b1;
        rparam = 8'h10;
        // mode pins reach the link only on sck edges: short warm-up frame
        cmd(4, 64'h0, 0);
        cmd(14, {8'h0b, 24'h000030, 32'h0}, 2, 0);
        check(rx[7:0], 8'h95);
        $display("test reads done");
        test_done();
    end
endmodule // flash_cmd_seq_test
`default_nettype wire

// ==== test/spi_host_model.sv ====
/* host serial master model: whole frames, sck runs only inside frames.
   assumes the device samples on sck rise and drives on sck fall. */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // link out
    output logic            sck_o,
    output logic            cs_n_o,
    output logic      [3:0] io_o,
    // device answer
    input  wire logic [3:0] io_i,
    input  wire logic [3:0] oe_i,
    output logic            saw_oe_o
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h0;
        saw_oe_o = 1'b0;
    end
    // host side, cs rises after the last bit
    task automatic frame(input int ntx, input logic [63:0] tx,
                         input int nrx, output logic [31:0] rx,
                         input int q);
        logic [3:0] v;
        rx = '0;
        saw_oe_o = 1'b0;
        cs_n_o = 1'b0;
        for (int k = 0; k < ntx + nrx; k++) begin
            // released lane toggles so stale data never matches
            if (k >= ntx) io_o = ~io_o;
            else if (k < q) io_o = {3'h0, tx[63-k]};
            // one nibble per clock after the first q clocks
            else io_o = tx[63-q-4*(k-q) -: 4];
            #62.5 sck_o = 1'b1;
            // undriven lanes read back inverted, never stale
            v = io_i ^ ~oe_i;
            if (k >= ntx && k < q) rx = {rx[30:0], v[1]};
            else if (k >= ntx) rx = {rx[27:0], v};
            saw_oe_o = saw_oe_o | (|oe_i);
            #62.5 sck_o = 1'b0;
        end
        #62.5 cs_n_o = 1'b1;
        io_o = ~io_o;
    endtask
endmodule // spi_host_model
`default_nettype wire

// ==== verilog/flash_cmd_pkg.sv ====
/*
 * Constants, carriers and helpers for the serial flash command sequencer.
 * Assumes a core clock of 40 MHz and a serial clock owned by the host.
 */
// Function
// - write-enable code sets latch at frame end
// - volatile enable: status write, latch untouched
// - write-disable code clears the latch
// - latch clear at reset, write completion
// - status one or two out, MSB first
// - status reads anytime, byte repeats
// - status write touches only writable bits
// - wrong data length discards status write
// - one byte write clears register two bits
// - self-timed write holds busy set
// - busy set clears the latch
// - register two write: one byte, latch needed
// - read streams bytes, address increments
// - plain read ignored while busy
// - fast read: address, dummies, data
// - quad address four bits per clock
// - quad read: six dummies, high nibble
// - quad mode dummies four, six, eight

`default_nettype none

package flash_cmd_pkg;

    // -------------------------------------------------------------
    // command codes
    // -------------------------------------------------------------
    localparam logic [7:0] CMD_WR_EN    = 8'h06;
    localparam logic [7:0] CMD_WR_DIS   = 8'h04;
    localparam logic [7:0] CMD_VOL_EN   = 8'h50;
    localparam logic [7:0] CMD_RD_ST1   = 8'h05;
    localparam logic [7:0] CMD_RD_ST2   = 8'h35;
    localparam logic [7:0] CMD_WR_ST    = 8'h01;
    localparam logic [7:0] CMD_WR_ST2   = 8'h31;
    localparam logic [7:0] CMD_READ     = 8'h03;
    localparam logic [7:0] CMD_FAST     = 8'h0b;
    localparam logic [7:0] CMD_QUAD_IO  = 8'heb;
    localparam logic [7:0] CMD_WRAP_SET = 8'h77;

    // -------------------------------------------------------------
    // status fields
    // -------------------------------------------------------------
    localparam int         ST1_BUSY     = 0;
    localparam int         ST2_QUAD_EN  = 1;
    localparam logic [7:0] ST1_WR_MASK  = 8'hfc;
    localparam logic [7:0] ST2_WR_MASK  = 8'h43;

    // -------------------------------------------------------------
    // frame positions, in serial clocks (bits for status writes)
    // -------------------------------------------------------------
    localparam logic [7:0] LEN_CMD_SPI  = 8'h08;
    localparam logic [7:0] LEN_CMD_QUAD = 8'h02;
    localparam logic [7:0] AEND_SPI     = 8'h20;
    localparam logic [7:0] AEND_QUAD    = 8'h08;
    localparam logic [7:0] FAST_DATA    = 8'h28;
    localparam logic [7:0] QIO_AEND     = 8'h0e;
    localparam logic [7:0] QIO_DATA     = 8'h14;
    localparam logic [7:0] WRAP_CLK_SPI = 8'h0f;
    localparam logic [7:0] WRAP_CLK_QD  = 8'h09;
    localparam logic [7:0] WRAP_END_SPI = 8'h10;
    localparam logic [7:0] WRAP_END_QD  = 8'h0a;
    localparam logic [7:0] LAST_SINGLE  = 8'h07;
    localparam logic [7:0] LAST_QUAD    = 8'h01;
    localparam logic [7:0] CNT_MAX      = 8'hff;
    localparam logic [9:0] BITS_BYTE    = 10'h008;
    localparam logic [9:0] BITS_ONE     = 10'h010;
    localparam logic [9:0] BITS_TWO     = 10'h018;
    localparam logic [7:0] DUMMY_4      = 8'h04;
    localparam logic [7:0] DUMMY_6      = 8'h06;
    localparam logic [7:0] DUMMY_8      = 8'h08;
    localparam int         SO_LANE      = 1;
    localparam logic [3:0] SO_OE        = 4'h2;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int STATUS_WRITE_TIME_US = 10000;
    localparam int REF_CLK_MHZ          = 40;
    localparam int TW_CYCLES = STATUS_WRITE_TIME_US * REF_CLK_MHZ;
    localparam int TIMER_W              = 20;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0] st2;
        logic [7:0] st1;
    } status_pair_s;

    typedef struct packed {
        logic       ok;
        logic       stat;
        logic       quad;
        logic [7:0] aend;
        logic [7:0] dstart;
    } read_plan_s;

    typedef struct packed {
        logic [7:0]  cnt;
        logic [31:0] sh;
        logic [7:0]  cmd;
        logic [23:0] addr;
        logic [2:0]  wrap;
        logic        quad_wide_command_mode;
    } link_s;

    typedef struct packed {
        logic [3:0] io;
        logic [3:0] oe;
    } pin_s;

    typedef struct packed {
        logic               busy;
        logic               write_enable_latch;
        logic               vol;
        status_pair_s       st;
        status_pair_s       nv;
        status_pair_s       pend;
        status_pair_s       view;
        logic [TIMER_W-1:0] timer;
        logic [2:0]         wrap;
        logic               cs_prev;
    } core_s;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] nw,
                                         input logic [7:0] m);
        return (old & ~m) | (nw & m);
    endfunction

    function automatic logic [7:0] dummy_clocks(input logic [1:0] sel);
        case (sel)
            2'h0:    return DUMMY_4;
            2'h1:    return DUMMY_6;
            default: return DUMMY_8;
        endcase
    endfunction

    // where address ends and data starts for each read command
    function automatic read_plan_s read_plan(input logic [7:0]   cmd,
                                             input logic         quad_wide_command_mode,
                                             input logic [1:0]   dsel,
                                             input status_pair_s st,
                                             input logic         valid);
        read_plan_s p;
        p      = '0;
        p.quad = quad_wide_command_mode;
        case (cmd)
            CMD_RD_ST1, CMD_RD_ST2: begin
                p.ok     = 1'b1;
                p.stat   = 1'b1;
                p.dstart = quad_wide_command_mode ? LEN_CMD_QUAD : LEN_CMD_SPI;
            end
            CMD_READ: begin
                p.ok     = !quad_wide_command_mode && !st.st1[ST1_BUSY];
                p.aend   = AEND_SPI;
                p.dstart = AEND_SPI;
            end
            CMD_FAST: begin
                p.ok     = 1'b1;
                p.aend   = quad_wide_command_mode ? AEND_QUAD : AEND_SPI;
                p.dstart = quad_wide_command_mode ? AEND_QUAD + dummy_clocks(dsel)
                               : FAST_DATA;
            end
            CMD_QUAD_IO: begin
                p.ok     = quad_wide_command_mode || st.st2[ST2_QUAD_EN];
                p.quad   = 1'b1;
                p.aend   = quad_wide_command_mode ? AEND_QUAD : QIO_AEND;
                p.dstart = quad_wide_command_mode ? AEND_QUAD + dummy_clocks(dsel)
                               : QIO_DATA;
            end
            default: ;
        endcase
        p.ok = p.ok && valid;
        return p;
    endfunction

endpackage

`default_nettype wire

// ==== verilog/flash_cmd_seq.sv ====
/*
 * Serial flash command sequencer: latch, status, plain/fast/quad reads.
 * Assumes the host drives sck and frames with cs_n; array is combinational
 * on the link clock; core clock 40 MHz.
 */
`timescale 1ns/1ps
`default_nettype none

module flash_cmd_seq
    import flash_cmd_pkg::*;
#(
    parameter int TW_CLKS = TW_CYCLES
) (
    // core clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    // serial link
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe_o,
    // configuration
    input  wire logic        quad_wide_command_mode_i,
    input  wire logic [7:0]  read_param_i,
    // array, link clock
    output logic      [23:0] array_addr_o,
    input  wire logic [7:0]  array_data_i,
    // status
    output status_pair_s     status_o,
    output status_pair_s     nv_status_o,
    output logic      [2:0]  wrap_length_o
);

    // -------------------------------------------------------------
    // link side
    // -------------------------------------------------------------
    logic         frame_rst_n;
    logic         in_frame_q;
    logic [18:0]  cfg_l;
    status_pair_s st_l;
    logic         qpi_l;
    logic [1:0]   dsel_l;
    link_s        link_q;
    link_s        link_d;
    pin_s         pin_q;
    pin_s         pin_d;
    read_plan_s   plan;
    logic         qpi_now;
    logic         cmd_ok;
    logic         dphase;
    logic         quad_in;
    logic [7:0]   cmd_len;
    logic [7:0]   off;
    logic [7:0]   last;
    logic [7:0]   src;
    core_s        core_q;
    core_s        core_d;

    // frame state ends with the frame itself, sck may stop
    assign frame_rst_n = resetn_i & ~cs_n_i;

    always_ff @(posedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= 1'b1;
        end
    end

    // status and config brought onto the link clock
    sync_2ff #(.W(19), .RST(19'h0)) u_cfg_sync (
        .clk_i    (sck_i),
        .resetn_i (resetn_i),
        .d_i      ({core_q.view, quad_wide_command_mode_i,
                    read_param_i[5:4]}),
        .q_o      (cfg_l)
    );
    assign st_l   = cfg_l[18:3];
    assign qpi_l  = cfg_l[2];
    assign dsel_l = cfg_l[1:0];

    // decode of the running frame
    always_comb begin
        qpi_now = in_frame_q ? link_q.quad_wide_command_mode : qpi_l;
        cmd_len = qpi_now ? LEN_CMD_QUAD : LEN_CMD_SPI;
        cmd_ok  = in_frame_q && (link_q.cnt >= cmd_len);
        plan    = read_plan(link_q.cmd, qpi_now, dsel_l, st_l, cmd_ok);
        off     = link_q.cnt - plan.dstart;
        last    = plan.quad ? LAST_QUAD : LAST_SINGLE;
        dphase  = plan.ok && (link_q.cnt >= plan.dstart);
        quad_in = qpi_now || (cmd_ok && (link_q.cmd == CMD_QUAD_IO ||
                                         link_q.cmd == CMD_WRAP_SET));
    end

    // rising edge: shift in, count, capture fields
    always_comb begin
        link_d     = link_q;
        link_d.quad_wide_command_mode = qpi_now;
        link_d.sh  = quad_in ? {link_q.sh[27:0], io_i}
                             : {link_q.sh[30:0], io_i[0]};
        if (!in_frame_q) begin
            link_d.cnt = 8'h01;
        end else if (dphase && off == last) begin
            link_d.cnt = plan.dstart;
            if (!plan.stat) begin
                link_d.addr = link_q.addr + 24'h1;
            end
        end else begin
            if (link_q.cnt != CNT_MAX) begin
                link_d.cnt = link_q.cnt + 8'h01;
            end
            if (plan.ok && link_d.cnt == plan.aend) begin
                link_d.addr = link_d.sh[23:0];
            end
        end
        if (in_frame_q && !cmd_ok && link_d.cnt == cmd_len) begin
            link_d.cmd = link_d.sh[7:0];
        end
        if (cmd_ok && link_q.cmd == CMD_WRAP_SET &&
            link_d.cnt == (qpi_now ? WRAP_CLK_QD : WRAP_CLK_SPI)) begin
            link_d.wrap = io_i[2:0];
        end
    end

    always_ff @(posedge sck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link_q <= '0;
        end else begin
            link_q <= link_d;
        end
    end

    // falling edge: drive the data lanes
    always_comb begin
        pin_d = '0;
        src   = plan.stat ? (link_q.cmd == CMD_RD_ST2 ? st_l.st2
                                                      : st_l.st1)
                          : array_data_i;
        if (dphase) begin
            if (plan.quad) begin
                pin_d.io = off[0] ? src[3:0] : src[7:4];
                pin_d.oe = 4'hf;
            end else begin
                pin_d.io[SO_LANE] = src[3'h7 - off[2:0]];
                pin_d.oe          = SO_OE;
            end
        end
    end

    // lanes released as soon as the frame ends
    always_ff @(negedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            pin_q <= '0;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign io_o         = pin_q.io;
    assign io_oe_o      = pin_q.oe;
    assign array_addr_o = link_q.addr;

    // -------------------------------------------------------------
    // core side
    // -------------------------------------------------------------
    logic         cs_s;
    logic         cs_rise;
    logic         len1;
    logic         len2;
    logic         go;
    logic [9:0]   bits;
    status_pair_s nst;

    sync_2ff #(.W(1), .RST(1'b1)) u_cs_sync (
        .clk_i    (ref_clk_i),
        .resetn_i (resetn_i),
        .d_i      (cs_n_i),
        .q_o      (cs_s)
    );

    // link fields are still once cs is high, so read them at its edge
    always_comb begin
        core_d         = core_q;
        core_d.cs_prev = cs_s;
        cs_rise = cs_s && !core_q.cs_prev;
        bits    = link_q.quad_wide_command_mode ? {link_q.cnt, 2'b00} : {2'b00, link_q.cnt};
        len1    = bits == BITS_ONE;
        len2    = bits == BITS_TWO;
        nst     = core_q.st;
        go      = 1'b0;
        if (core_q.busy) begin
            if (core_q.timer == '0) begin
                core_d.busy = 1'b0;
                core_d.write_enable_latch  = 1'b0;
                core_d.st   = core_q.pend;
                core_d.nv   = core_q.pend;
            end else begin
                core_d.timer = core_q.timer - 1'b1;
            end
        end else if (cs_rise && bits >= BITS_BYTE) begin
            case (link_q.cmd)
                CMD_WR_EN:  core_d.write_enable_latch = 1'b1;
                CMD_WR_DIS: core_d.write_enable_latch = 1'b0;
                CMD_VOL_EN: core_d.vol = 1'b1;
                CMD_WRAP_SET: begin
                    if (link_q.cnt >= (link_q.quad_wide_command_mode ? WRAP_END_QD
                                                  : WRAP_END_SPI)) begin
                        core_d.wrap = link_q.wrap;
                    end
                end
                default: ;
            endcase
            if (link_q.cmd == CMD_WR_ST && (len1 || len2)) begin
                go      = 1'b1;
                nst.st1 = merge(core_q.st.st1,
                                len2 ? link_q.sh[15:8] : link_q.sh[7:0],
                                ST1_WR_MASK);
                nst.st2 = len2 ? merge(core_q.st.st2, link_q.sh[7:0],
                                       ST2_WR_MASK)
                               : core_q.st.st2 & ~ST2_WR_MASK;
            end
            if (link_q.cmd == CMD_WR_ST2 && len1) begin
                go      = 1'b1;
                nst.st2 = merge(core_q.st.st2, link_q.sh[7:0],
                                ST2_WR_MASK);
            end
            if (go && core_q.vol) begin
                // volatile path: no timed cycle
                core_d.st  = nst;
                core_d.vol = 1'b0;
            end else if (go && core_q.write_enable_latch) begin
                core_d.pend  = nst;
                core_d.busy  = 1'b1;
                core_d.write_enable_latch   = 1'b0;
                core_d.timer = TIMER_W'(TW_CLKS - 1);
            end
        end
        core_d.view     = core_d.st;
        core_d.view.st1 = core_d.st.st1 | {6'h00, core_d.write_enable_latch, core_d.busy};
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_q         <= '0;
            core_q.cs_prev <= 1'b1;
        end else begin
            core_q <= core_d;
        end
    end

    assign status_o      = core_q.view;
    assign nv_status_o   = core_q.nv;
    assign wrap_length_o = core_q.wrap;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    sequence s_wr_frame;
        cs_rise && !core_q.busy && link_q.cmd == CMD_WR_ST &&
        bits >= BITS_BYTE;
    endsequence
    sequence s_cycle_start;
        $rose(core_q.busy);
    endsequence
    a_wel_set: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        cs_rise && !core_q.busy && bits >= BITS_BYTE &&
        link_q.cmd == CMD_WR_EN |=> core_q.write_enable_latch)
        else $error("latch not set");
    a_wel_clear: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        cs_rise && !core_q.busy && bits >= BITS_BYTE &&
        link_q.cmd == CMD_WR_DIS |=> !core_q.write_enable_latch)
        else $error("latch not cleared");
    a_vol_keeps_wel: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        cs_rise && !core_q.busy && bits >= BITS_BYTE &&
        link_q.cmd == CMD_VOL_EN |=> $stable(core_q.write_enable_latch) && core_q.vol)
        else $error("volatile enable touched latch");
    a_busy_drops_wel: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_cycle_start |-> !core_q.write_enable_latch && !status_o.st1[1])
        else $error("latch still set while busy");
    a_bad_length: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_wr_frame ##0 (!len1 && !len2) |=>
        !core_q.busy && $stable(core_q.st))
        else $error("bad length write executed");
    a_one_byte: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_wr_frame ##0 (len1 && core_q.write_enable_latch && !core_q.vol) |=>
        core_q.busy && (core_q.pend.st2 & ST2_WR_MASK) == 8'h00)
        else $error("one byte write kept register two bits");
    a_busy_hold: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_cycle_start |-> core_q.busy [*8])
        else $error("write cycle ended early");
    a_cycle_done: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(core_q.busy) |->
        !core_q.write_enable_latch && core_q.st == $past(core_q.pend))
        else $error("completion did not clear latch");
    a_stat_repeat: assert property (
        @(posedge sck_i) disable iff (!frame_rst_n)
        dphase && plan.stat && off == last |=>
        link_q.cnt == $past(plan.dstart))
        else $error("status byte not repeated");
    a_addr_step: assert property (
        @(posedge sck_i) disable iff (!frame_rst_n)
        dphase && !plan.stat && off == last |=>
        link_q.addr == $past(link_q.addr) + 24'h1)
        else $error("address not incremented");
    a_msb_first: assert property (
        @(posedge sck_i) disable iff (!frame_rst_n)
        dphase && plan.stat && !plan.quad && off == 8'h00 |->
        pin_q.io[SO_LANE] == src[7] && pin_q.oe == SO_OE)
        else $error("status msb not first");

endmodule // flash_cmd_seq

`default_nettype wire

// ==== verilog/sync_2ff.sv ====
/*
 * Two-stage level synchroniser, width and reset value set by parameters.
 * Assumes inputs are levels or quasi-static words.
 */
`timescale 1ns/1ps
`default_nettype none

module sync_2ff
    import flash_cmd_pkg::*;
#(
    parameter int unsigned    W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [1:0][W-1:0] stg_q;
    logic [1:0][W-1:0] stg_d;

    // first stage feeds only the second
    always_comb begin
        stg_d = {stg_q[0], d_i};
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stg_q <= {RST, RST};
        end else begin
            stg_q <= stg_d;
        end
    end

    assign q_o = stg_q[1];

endmodule // sync_2ff

`default_nettype wire
